// *** rtl/sap_defines.svh ***
// Constants for the serial alternate port pin block
// Functional notes
// - Direction write loads flop; read returns it
// - Reset clears direction bits to input
// - Tx pin direction 1: drive, read latch
// - Direction 0, transmitter idle: float, read pin
// - Data write always loads output latch
// - Transmitter active forces drive of tx bit
// - Transmitter idle: latch data, direction enables
// - Open-drain select: drive low only
// - Tx pin read source follows direction bit
// - Transmitter active holds through final character
// - Tx finished: revert to direction and latch
// - Mode fault clears slave-out direction bit
// - Fault when master sees slave select
// - Slave-out pin: off as master, else direction
// - SPI enable picks slave data over latch
// - Slave-out read: internal data if driven
// - Slave-out pin level always feeds SPI input
`ifndef SAP_DEFINES_SVH
`define SAP_DEFINES_SVH
`define SAP_TX_BIT      0
`define SAP_SO_BIT      1
`define SAP_NPINS       2
`define SAP_DIR_RESET   2'h0
`define SAP_DATA_RESET  2'h0
`endif

// *** rtl/sap_pkg.sv ***
// Types for the serial alternate port pin block
package sap_pkg;
  typedef struct packed {
    logic [1:0] dout;
    logic [1:0] oe;
  } sap_pad_s;
endpackage

// *** rtl/sap_port_pins.sv ***
// Port pins shared with the serial transmitter and the SPI slave output
`timescale 1ns/100ps
`include "sap_defines.svh"
module sap_port_pins
  import sap_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_arst_n,
  input  wire logic [1:0] i_bus_wdata,
  input  wire logic       i_direction_write_strobe,
  input  wire logic       i_direction_read_strobe,
  input  wire logic       i_port_write_strobe,
  input  wire logic       i_port_read_strobe,
  input  wire logic       i_port_open_drain_select,
  input  wire logic       i_transmitter_active,
  input  wire logic       i_serial_tx_bit,
  input  wire logic       i_spi_enable_bit,
  input  wire logic       i_spi_slave_active,
  input  wire logic       i_spi_slave_out_bit,
  input  wire logic       i_spi_master_cfg,
  input  wire logic       i_spi_slave_select_n,
  input  wire logic [1:0] i_pin,
  output logic [1:0]      o_pin_out,
  output logic [1:0]      o_pin_oe,
  output logic [1:0]      o_direction_rdata,
  output logic [1:0]      o_port_rdata,
  output logic            o_spi_master_data_in,
  output logic            o_spi_mode_fault
);

////////////////////////////////////////////////////////////////////////////
  logic       rst_meta_r;
  logic       rst_sync_r;
  logic [1:0] dir_r;
  logic [1:0] latch_r;
  logic       fault_nxt;
  sap_pad_s   pad_nxt;
  logic [1:0] drv_nxt;
  logic [1:0] rd_nxt;

  // Slave-out pin drive decision, shared by the pad enable and the read mux
  // so the read-back source matches the pad enable except when open drain releases a 1.
  function automatic logic so_drive(input logic dir,
                                    input logic spi_enable_bit,
                                    input logic slave);
    so_drive = dir & ~(spi_enable_bit & ~slave);
  endfunction

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_r <= 1'h0;
      rst_sync_r <= 1'h0;
    end else begin
      rst_meta_r <= 1'h1;
      rst_sync_r <= rst_meta_r;
    end
  end

////////////////////////////////////////////////////////////////////////////
  // Master selected as a slave means another master is on the lines
  assign fault_nxt = i_spi_enable_bit & i_spi_master_cfg
                     & ~i_spi_slave_select_n;

  always_ff @(posedge i_sys_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      dir_r <= `SAP_DIR_RESET;
    end else begin
      if (i_direction_write_strobe) begin
        dir_r <= i_bus_wdata;
      end
      // Fault beats a same-cycle write to avoid a drive fight
      if (fault_nxt) begin
        dir_r[`SAP_SO_BIT] <= 1'h0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      latch_r <= `SAP_DATA_RESET;
    end else if (i_port_write_strobe) begin
      latch_r <= i_bus_wdata;
    end
  end

////////////////////////////////////////////////////////////////////////////
  // The transmitter keeps its active flag until the last stop bit,
  // so releasing on that flag never truncates a character.
  always_comb begin
    pad_nxt.oe[`SAP_TX_BIT] = dir_r[`SAP_TX_BIT]
                              | i_transmitter_active;
    drv_nxt[`SAP_TX_BIT]    = i_transmitter_active ? i_serial_tx_bit
                              : latch_r[`SAP_TX_BIT];
    // Slave data needs the direction bit set by software
    pad_nxt.oe[`SAP_SO_BIT] = so_drive(dir_r[`SAP_SO_BIT],
                                       i_spi_enable_bit,
                                       i_spi_slave_active);
    drv_nxt[`SAP_SO_BIT]    = i_spi_enable_bit ? i_spi_slave_out_bit
                              : latch_r[`SAP_SO_BIT];
    // Open drain: a 1 releases the pin instead of driving high
    for (int i = 0; i < `SAP_NPINS; i++) begin
      pad_nxt.dout[i] = drv_nxt[i] & ~i_port_open_drain_select;
      if (i_port_open_drain_select && drv_nxt[i]) begin
        pad_nxt.oe[i] = 1'h0;
      end
    end
    rd_nxt[`SAP_TX_BIT] = dir_r[`SAP_TX_BIT] ? latch_r[`SAP_TX_BIT]
                          : i_pin[`SAP_TX_BIT];
    rd_nxt[`SAP_SO_BIT] = so_drive(dir_r[`SAP_SO_BIT], i_spi_enable_bit,
                                   i_spi_slave_active)
                          ? drv_nxt[`SAP_SO_BIT]
                          : i_pin[`SAP_SO_BIT];
  end

////////////////////////////////////////////////////////////////////////////
  // Outputs are registered, so pins follow their causes one cycle late
  always_ff @(posedge i_sys_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      o_pin_out <= 2'h0;
      o_pin_oe  <= 2'h0;
    end else begin
      o_pin_out <= pad_nxt.dout;
      o_pin_oe  <= pad_nxt.oe;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      o_direction_rdata <= 2'h0;
      o_port_rdata      <= 2'h0;
    end else begin
      o_direction_rdata <= i_direction_read_strobe ? dir_r : 2'h0;
      o_port_rdata      <= i_port_read_strobe ? rd_nxt : 2'h0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      o_spi_master_data_in <= 1'h0;
      o_spi_mode_fault     <= 1'h0;
    end else begin
      o_spi_master_data_in <= i_pin[`SAP_SO_BIT];
      o_spi_mode_fault     <= fault_nxt;
    end
  end

////////////////////////////////////////////////////////////////////////////
  chk_dir_reset_zero: assert property (@(posedge i_sys_clk)
    $rose(rst_sync_r) |-> dir_r == 2'h0)
    else $error("direction not cleared by reset");

  chk_dir_write_load: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    i_direction_write_strobe && !fault_nxt |=> dir_r == $past(i_bus_wdata))
    else $error("direction write not loaded");

  chk_latch_write: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    i_port_write_strobe |=> latch_r == $past(i_bus_wdata))
    else $error("port write not latched");

  chk_tx_force_on: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    i_transmitter_active && !i_port_open_drain_select |=>
      o_pin_oe[0] && o_pin_out[0] == $past(i_serial_tx_bit))
    else $error("transmitter did not drive pin");

  chk_tx_idle_float: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    !i_transmitter_active && !dir_r[0] |=> !o_pin_oe[0])
    else $error("idle tx pin driven");

  chk_tx_read_src: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    i_port_read_strobe |=> o_port_rdata[0] ==
      ($past(dir_r[0]) ? $past(latch_r[0]) : $past(i_pin[0])))
    else $error("tx read source wrong");

  chk_open_drain_hi: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    i_port_open_drain_select |=> !(o_pin_oe[0] && o_pin_out[0])
      && !(o_pin_oe[1] && o_pin_out[1]))
    else $error("open drain pin driven high");

  chk_fault_clear: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    fault_nxt |=> !dir_r[1] ##1 !o_pin_oe[1])
    else $error("mode fault left pin driven");

  chk_so_master_off: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    i_spi_enable_bit && !i_spi_slave_active |=> !o_pin_oe[1])
    else $error("slave out driven as master");

  chk_so_data_src: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    i_spi_enable_bit && !i_port_open_drain_select && pad_nxt.oe[1] |=>
      o_pin_out[1] == $past(i_spi_slave_out_bit))
    else $error("slave out data source wrong");

  chk_miso_feed: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    1'b1 |=> o_spi_master_data_in == $past(i_pin[1]))
    else $error("spi input not fed from pin");

  // Reset checks run without a disable so they see the reset itself
  chk_reset_pins: assert property (@(posedge i_sys_clk)
    !rst_sync_r |-> o_pin_oe == 2'h0 && o_pin_out == 2'h0)
    else $error("pins active during reset");

  chk_reset_reads: assert property (@(posedge i_sys_clk)
    !rst_sync_r |-> o_direction_rdata == 2'h0 && o_port_rdata == 2'h0)
    else $error("read data active during reset");

  chk_dir_read_data: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    i_direction_read_strobe |=> o_direction_rdata == $past(dir_r))
    else $error("direction read data wrong");

  chk_dir_read_idle: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    !i_direction_read_strobe |=> o_direction_rdata == 2'h0)
    else $error("direction read data without strobe");

  chk_port_read_idle: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    !i_port_read_strobe |=> o_port_rdata == 2'h0)
    else $error("port read data without strobe");

  chk_tx_dir_drive: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    dir_r[0] && !i_port_open_drain_select |=> o_pin_oe[0])
    else $error("tx pin output not driven");

  chk_tx_read_latch: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    i_port_read_strobe && dir_r[0] |=> o_port_rdata[0] == $past(latch_r[0]))
    else $error("tx read not from latch");

  chk_tx_read_active: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    i_port_read_strobe && i_transmitter_active && !dir_r[0] |=>
      o_port_rdata[0] == $past(i_pin[0]))
    else $error("tx read not from pin while sending");

  chk_tx_idle_data: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    !i_transmitter_active && !i_port_open_drain_select |=>
      o_pin_out[0] == $past(latch_r[0]))
    else $error("idle tx pin data not from latch");

  chk_tx_idle_oe: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    !i_transmitter_active && !i_port_open_drain_select |=>
      o_pin_oe[0] == $past(dir_r[0]))
    else $error("idle tx pin enable not from direction");

  // A character in flight keeps the pin whatever the direction bit says
  chk_tx_active_oe: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    i_transmitter_active && !(i_port_open_drain_select && i_serial_tx_bit)
      |=> o_pin_oe[0])
    else $error("tx pin released mid character");

  chk_tx_active_od: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    i_transmitter_active && i_port_open_drain_select |=>
      !o_pin_out[0] && o_pin_oe[0] == !$past(i_serial_tx_bit))
    else $error("open drain tx data wrong");

  chk_tx_revert: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    $fell(i_transmitter_active) && !i_port_open_drain_select |=>
      o_pin_oe[0] == $past(dir_r[0]) && o_pin_out[0] == $past(latch_r[0]))
    else $error("tx pin did not revert");

  chk_od_low_only: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    i_port_open_drain_select |=> o_pin_out == 2'h0)
    else $error("open drain drove a one");

  chk_od_zero_driven: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    i_port_open_drain_select && !i_transmitter_active && dir_r[0]
      && !latch_r[0] |=> o_pin_oe[0])
    else $error("open drain zero not driven");

  chk_od_so_release: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    i_port_open_drain_select && i_spi_enable_bit && i_spi_slave_out_bit
      |=> !o_pin_oe[1])
    else $error("open drain slave one driven");

  chk_fault_raise: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    i_spi_enable_bit && i_spi_master_cfg && !i_spi_slave_select_n
      |=> o_spi_mode_fault)
    else $error("mode fault not raised");

  chk_fault_quiet: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    !(i_spi_enable_bit && i_spi_master_cfg && !i_spi_slave_select_n)
      |=> !o_spi_mode_fault)
    else $error("mode fault raised without cause");

  // A write in the fault cycle must not re-enable the contested pin
  chk_fault_dir_win: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    fault_nxt && i_direction_write_strobe |=>
      !dir_r[1] && dir_r[0] == $past(i_bus_wdata[0]))
    else $error("write beat mode fault");

  chk_fault_keep_tx: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    fault_nxt && !i_direction_write_strobe |=> dir_r[0] == $past(dir_r[0]))
    else $error("mode fault touched tx direction");

  chk_so_off_dir: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    !i_spi_enable_bit && !i_port_open_drain_select |=>
      o_pin_oe[1] == $past(dir_r[1]))
    else $error("slave out enable not from direction");

  chk_so_slave_dir: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    i_spi_enable_bit && i_spi_slave_active && !i_port_open_drain_select
      |=> o_pin_oe[1] == $past(dir_r[1]))
    else $error("slave enable not from direction");

  chk_so_latch_src: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    !i_spi_enable_bit && !i_port_open_drain_select |=>
      o_pin_out[1] == $past(latch_r[1]))
    else $error("slave out data not from latch");

  chk_so_read_drv: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    i_port_read_strobe
      && so_drive(dir_r[1], i_spi_enable_bit, i_spi_slave_active) |=>
      o_port_rdata[1] == $past(i_spi_enable_bit ? i_spi_slave_out_bit
                                                : latch_r[1]))
    else $error("slave out read not internal data");

  chk_so_read_pin: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    i_port_read_strobe
      && !so_drive(dir_r[1], i_spi_enable_bit, i_spi_slave_active) |=>
      o_port_rdata[1] == $past(i_pin[1]))
    else $error("slave out read not from pin");

  chk_dir_hold: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    !i_direction_write_strobe && !fault_nxt |=> $stable(dir_r))
    else $error("direction changed without write");

  chk_latch_hold: assert property (@(posedge i_sys_clk)
    disable iff (!rst_sync_r)
    !i_port_write_strobe |=> $stable(latch_r))
    else $error("latch changed without write");

endmodule // sap_port_pins

// *** verif/sap_line_model.sv ***
// Far-side line model: pull-ups plus a peer that can pull lines low
`timescale 1ns/100ps
module sap_line_model (
  input  wire logic [1:0] i_pin_out,
  input  wire logic [1:0] i_pin_oe,
  input  wire logic [1:0] i_ext_low,
  output logic      [1:0] o_level
);
  // Undriven lines rest high; a low pull wins any contention
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      o_level[b] = (i_pin_oe[b] ? i_pin_out[b] : 1'b1) & ~i_ext_low[b];
    end
  end
endmodule // sap_line_model

// *** verif/sap_port_pins_test.sv ***
// Self-checking bench for the serial alternate port pins
`timescale 1ns/100ps
module sap_port_pins_test;
  logic       clk;
  logic       rst_n;
  logic [1:0] wd;
  logic [3:0] stb;
  logic       od, txa, txb, spi_enable_bit, sla, sob, mcfg, ssn;
  logic [1:0] ext, pin, pout, poe, drd, prd;
  logic       mdi, flt;
  int         cyc, n_fail, n_compared;
  //////////////////////////////////////////////////////////////////////
  sap_port_pins u_dut (
    .i_sys_clk(clk), .i_arst_n(rst_n), .i_bus_wdata(wd),
    .i_direction_write_strobe(stb[0]), .i_direction_read_strobe(stb[1]),
    .i_port_write_strobe(stb[2]), .i_port_read_strobe(stb[3]),
    .i_port_open_drain_select(od), .i_transmitter_active(txa),
    .i_serial_tx_bit(txb), .i_spi_enable_bit(spi_enable_bit),
    .i_spi_slave_active(sla), .i_spi_slave_out_bit(sob),
    .i_spi_master_cfg(mcfg), .i_spi_slave_select_n(ssn), .i_pin(pin),
    .o_pin_out(pout), .o_pin_oe(poe), .o_direction_rdata(drd),
    .o_port_rdata(prd), .o_spi_master_data_in(mdi),
    .o_spi_mode_fault(flt));
  sap_line_model u_line (.i_pin_out(pout), .i_pin_oe(poe),
    .i_ext_low(ext), .o_level(pin));
  //////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic look(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Strobes sit for exactly one edge; reads are sampled just after it
  task automatic acc(input logic [3:0] s, input logic [1:0] d);
    @(posedge clk);
    stb <= s;
    wd  <= d;
    @(posedge clk);
    stb <= 4'h0;
    #1;
  endtask
  task automatic chk(input logic [1:0] s, input logic [1:0] e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("FAIL t=%0t seen %b expected %b", $time, s, e);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // The whole sequence needs under a hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    {od, txa, txb, spi_enable_bit, sla, sob, mcfg} = 7'h00;
    {rst_n, wd, stb, ext} = 9'h000;
    {ssn, cyc, n_fail, n_compared} = '0;
    ssn = 1'b1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    look(4);
    chk(poe, 2'h0);
    acc(4'h2, 2'h0);
    chk(drd, 2'h0);
    acc(4'h1, 2'h3);
    acc(4'h4, 2'h1);
    acc(4'h2, 2'h0);
    chk(drd, 2'h3);
    look(1);
    chk(poe, 2'h3);
    chk(pout, 2'h1);
    ext <= 2'h1;
    acc(4'h8, 2'h0);
    chk(prd, 2'h1);
    acc(4'h1, 2'h0);
    {ext, txa, txb} <= 4'h2;
    look(2);
    chk(poe, 2'h1);
    chk({1'b0, pout[0]}, 2'h0);
    acc(4'h8, 2'h0);
    chk(prd, 2'h2);
    txb <= 1'b1;
    look(2);
    acc(4'h8, 2'h0);
    chk(prd, 2'h3);
    {ext, txa} <= 3'h2;
    look(2);
    chk(poe, 2'h0);
    acc(4'h8, 2'h0);
    chk(prd, 2'h2);
    {ext, txa, txb} <= 4'h2;
    acc(4'h1, 2'h1);
    acc(4'h4, 2'h1);
    look(1);
    chk({1'b0, pout[0]}, 2'h0);
    txa <= 1'b0;
    look(2);
    chk({1'b0, pout[0]}, 2'h1);
    chk(poe, 2'h1);
    acc(4'h1, 2'h3);
    acc(4'h4, 2'h3);
    od <= 1'b1;
    look(2);
    chk(poe, 2'h0);
    acc(4'h4, 2'h0);
    look(1);
    chk(poe, 2'h3);
    chk(pout, 2'h0);
    {od, spi_enable_bit, sla, sob} <= 4'h7;
    look(2);
    chk(poe, 2'h3);
    chk({pout[1], 1'b0}, 2'h2);
    acc(4'h8, 2'h0);
    chk(prd, 2'h2);
    {sla, sob} <= 2'h0;
    look(2);
    chk(poe, 2'h1);
    ext <= 2'h2;
    look(2);
    chk({1'b0, mdi}, 2'h0);
    {ext, mcfg, ssn} <= 4'h2;
    look(2);
    chk({1'b0, flt}, 2'h1);
    acc(4'h1, 2'h3);
    acc(4'h2, 2'h0);
    chk(drd, 2'h1);
    ssn <= 1'b1;
    look(2);
    chk({1'b0, flt}, 2'h0);
    report_and_stop();
  end
endmodule // sap_port_pins_test
